/* File: logic/pmc_pkg.sv */
// Package of constants and types for the power mode controller
package pmc_pkg;
  localparam int PMC_NSUB = 8;
  localparam int PMC_SUB_CPU = 0;
  localparam int PMC_SUB_FLASH = 1;
  localparam int PMC_SUB_I2C = 2;
  localparam int PMC_SUB_CMP = 3;
  localparam int PMC_CLK_MHZ = 100;
  localparam int PMC_SLEEP_WAKE_NS = 15000;
  localparam int PMC_HIB_WAKE_NS = 100000;
  localparam int PMC_SLEEP_WAKE_CYC = PMC_SLEEP_WAKE_NS * PMC_CLK_MHZ / 1000 - 1;
  localparam int PMC_HIB_WAKE_CYC = PMC_HIB_WAKE_NS * PMC_CLK_MHZ / 1000 - 1;
  localparam int PMC_BUZZ_PERIOD = 1024;
  localparam int PMC_BUZZ_ON = 64;
  localparam int PMC_CNT_W = 16;
  localparam logic [PMC_NSUB-1:0] PMC_SLEEP_KEEP = 8'h0c;
  localparam int PMC_NWAKE = 6;
  localparam int PMC_WK_PORT = 1;

  typedef enum logic [1:0] {
    PMC_REQ_ACTIVE,
    PMC_REQ_ALT,
    PMC_REQ_SLEEP,
    PMC_REQ_HIB
  } pmc_req_type;

  typedef enum {
    PMC_ST_ACTIVE,
    PMC_ST_ALT,
    PMC_ST_SLEEP,
    PMC_ST_HIB,
    PMC_ST_RESUME
  } pmc_state_type;

  typedef struct packed {
    logic dig_reg_on;
    logic ana_reg_on;
    logic sleep_reg_on;
    logic hib_reg_on;
  } pmc_reg_type;

  typedef struct packed {
    logic cmp;
    logic port_interrupt_unit;
    logic i2c;
    logic rtc;
    logic central_timewheel;
    logic low_voltage_detect;
  } pmc_wake_type;
endpackage

/* File: logic/pmc_sync.sv */
// Two flip-flop synchroniser for a bus of level inputs
`timescale 1ns/1ns
module pmc_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout = stage1;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end
endmodule

/* File: logic/pmc_buzz.sv */
// Periodic burst enable for the core regulators in sleep
`timescale 1ns/1ns
module pmc_buzz #(
  parameter int PERIOD = 1024,
  parameter int ON_CYC = 64
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic run,
  output logic burst
);
  localparam int CW = $clog2(PERIOD);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_burst;

  if (ON_CYC < 1 || ON_CYC >= PERIOD) begin : g_bad_on
    $error("pmc_buzz: ON_CYC out of range");
  end

  always_comb begin
    next_cnt = '0;
    next_burst = 1'b0;
    if (run) begin
      next_cnt = (cnt == CW'(PERIOD - 1)) ? '0 : cnt + 1'b1;
      next_burst = (next_cnt < CW'(ON_CYC));
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      burst <= 1'b0;
    end else begin
      cnt <= next_cnt;
      burst <= next_burst;
    end
  end
endmodule

/* File: logic/pmc_top.sv */
// Global power mode controller: modes, templates, clock gates, regulators
`timescale 1ns/1ns
module pmc_top #(
  parameter int NSUB = pmc_pkg::PMC_NSUB,
  parameter int SLEEP_WAKE_CYC = pmc_pkg::PMC_SLEEP_WAKE_CYC,
  parameter int HIB_WAKE_CYC = pmc_pkg::PMC_HIB_WAKE_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [NSUB-1:0] act_template,
  input wire logic [NSUB-1:0] alt_template,
  input wire logic mode_req_wr,
  input wire pmc_pkg::pmc_req_type mode_req,
  input wire logic cpu_self_off,
  input wire logic ext_regulation,
  input wire pmc_pkg::pmc_wake_type wake_in,
  output logic [NSUB-1:0] sub_clk_en,
  output logic [NSUB-1:0] sub_bias_en,
  output logic slow_clk_en,
  output logic io_hold,
  output pmc_pkg::pmc_reg_type reg_ctl,
  output logic [1:0] mode_now,
  output logic wake_done
);
  import pmc_pkg::*;

  // ----------------------------------------
  // Checks and synchronised wakeups
  // ----------------------------------------
  if (NSUB < 4 || SLEEP_WAKE_CYC < 1 || HIB_WAKE_CYC < 1) begin : g_bad_param
    $error("pmc_top: parameter out of range");
  end
  if (SLEEP_WAKE_CYC >= 2**PMC_CNT_W || HIB_WAKE_CYC >= 2**PMC_CNT_W) begin : g_bad_cnt
    $error("pmc_top: wake count too wide");
  end

  logic [PMC_NWAKE-1:0] wake_sync;
  logic burst;

  pmc_sync #(
    .WIDTH(PMC_NWAKE)
  ) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .din(wake_in),
    .dout(wake_sync)
  );

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  pmc_state_type state;
  pmc_state_type next_state;
  logic [PMC_CNT_W-1:0] cnt;
  logic [PMC_CNT_W-1:0] next_cnt;
  logic cpu_off;
  logic next_cpu_off;
  logic cpu_force;
  logic next_cpu_force;
  logic any_wake;
  logic hib_wake;

  pmc_buzz #(
    .PERIOD(PMC_BUZZ_PERIOD),
    .ON_CYC(PMC_BUZZ_ON)
  ) u_buzz (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .run(state == PMC_ST_SLEEP),
    .burst(burst)
  );

  always_comb begin
    any_wake = |wake_sync;
    hib_wake = wake_sync[PMC_NWAKE-1-PMC_WK_PORT];
    next_state = state;
    next_cnt = cnt;
    next_cpu_off = cpu_off;
    next_cpu_force = cpu_force;
    if (cpu_self_off) begin
      next_cpu_off = 1'b1;
      next_cpu_force = 1'b0;
    end
    case (state)
      PMC_ST_ACTIVE, PMC_ST_ALT: begin
        if (any_wake) begin
          next_state = PMC_ST_ACTIVE;
          next_cpu_off = 1'b0;
          next_cpu_force = 1'b1;
        end else if (mode_req_wr) begin
          next_cpu_force = 1'b0;
          case (mode_req)
            PMC_REQ_ALT: next_state = PMC_ST_ALT;
            PMC_REQ_SLEEP: next_state = PMC_ST_SLEEP;
            PMC_REQ_HIB: next_state = PMC_ST_HIB;
            default: next_state = PMC_ST_ACTIVE;
          endcase
        end
      end
      PMC_ST_SLEEP: begin
        if (any_wake) begin
          next_state = PMC_ST_RESUME;
          next_cnt = PMC_CNT_W'(SLEEP_WAKE_CYC - 1);
        end
      end
      PMC_ST_HIB: begin
        if (hib_wake) begin
          next_state = PMC_ST_RESUME;
          next_cnt = PMC_CNT_W'(HIB_WAKE_CYC - 1);
        end
      end
      PMC_ST_RESUME: begin
        if (cnt == '0) begin
          next_state = PMC_ST_ACTIVE;
          next_cpu_off = 1'b0;
          next_cpu_force = 1'b1;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: next_state = PMC_ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= PMC_ST_ACTIVE;
      cnt <= '0;
      cpu_off <= 1'b0;
      cpu_force <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cpu_off <= next_cpu_off;
      cpu_force <= next_cpu_force;
    end
  end

  // ----------------------------------------
  // Resource enables and regulators
  // ----------------------------------------
  logic [NSUB-1:0] next_sub_en;
  logic next_slow_clk_en;
  logic next_io_hold;
  pmc_reg_type next_reg_ctl;
  logic [1:0] next_mode_now;
  logic next_wake_done;
  logic [NSUB-1:0] keep;

  always_comb begin
    keep = NSUB'(PMC_SLEEP_KEEP);
    next_sub_en = '0;
    next_slow_clk_en = 1'b1;
    next_io_hold = 1'b0;
    next_reg_ctl.dig_reg_on = !ext_regulation;
    next_reg_ctl.ana_reg_on = !ext_regulation;
    next_reg_ctl.sleep_reg_on = 1'b0;
    next_reg_ctl.hib_reg_on = 1'b0;
    next_mode_now = 2'(PMC_REQ_ACTIVE);
    next_wake_done = 1'b0;
    case (next_state)
      PMC_ST_ACTIVE: begin
        next_sub_en = act_template;
        next_sub_en[PMC_SUB_CPU] = (act_template[PMC_SUB_CPU] || next_cpu_force) &&
          !next_cpu_off;
        next_wake_done = (state == PMC_ST_RESUME);
      end
      PMC_ST_ALT: begin
        next_sub_en = alt_template;
        next_sub_en[PMC_SUB_CPU] = alt_template[PMC_SUB_CPU] && !next_cpu_off;
        next_mode_now = 2'(PMC_REQ_ALT);
      end
      PMC_ST_SLEEP, PMC_ST_RESUME: begin
        next_sub_en = (next_state == PMC_ST_SLEEP) ? keep : '0;
        next_reg_ctl.dig_reg_on = !ext_regulation &&
          (burst || next_state == PMC_ST_RESUME);
        next_reg_ctl.ana_reg_on = !ext_regulation &&
          (burst || next_state == PMC_ST_RESUME);
        next_reg_ctl.sleep_reg_on = 1'b1;
        next_mode_now = 2'(PMC_REQ_SLEEP);
      end
      PMC_ST_HIB: begin
        next_slow_clk_en = 1'b0;
        next_io_hold = 1'b1;
        next_reg_ctl = '0;
        next_reg_ctl.hib_reg_on = 1'b1;
        next_mode_now = 2'(PMC_REQ_HIB);
      end
      default: next_sub_en = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sub_clk_en <= '0;
      sub_bias_en <= '0;
      slow_clk_en <= 1'b1;
      io_hold <= 1'b0;
      reg_ctl <= '0;
      mode_now <= 2'(PMC_REQ_ACTIVE);
      wake_done <= 1'b0;
    end else begin
      sub_clk_en <= next_sub_en;
      sub_bias_en <= next_sub_en;
      slow_clk_en <= next_slow_clk_en;
      io_hold <= next_io_hold;
      reg_ctl <= next_reg_ctl;
      mode_now <= next_mode_now;
      wake_done <= next_wake_done;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [PMC_CNT_W-1:0] resume_age;
  logic [PMC_CNT_W-1:0] next_resume_age;
  logic from_sleep;
  logic next_from_sleep;

  // Cycles spent in resume, and whether it began in sleep
  always_comb begin
    next_resume_age = '0;
    next_from_sleep = from_sleep;
    if (state == PMC_ST_RESUME) begin
      next_resume_age = resume_age + 1'b1;
    end
    if (state == PMC_ST_SLEEP) begin
      next_from_sleep = 1'b1;
    end else if (state == PMC_ST_HIB) begin
      next_from_sleep = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      resume_age <= '0;
      from_sleep <= 1'b0;
    end else begin
      resume_age <= next_resume_age;
      from_sleep <= next_from_sleep;
    end
  end

  sequence s_sleep_wake;
    state == PMC_ST_SLEEP && any_wake;
  endsequence

  sequence s_hib_wake;
    state == PMC_ST_HIB && hib_wake;
  endsequence

  property p_reset_active;
    @(posedge clk_sys) $rose(rstn) |-> mode_now == 2'(PMC_REQ_ACTIVE);
  endproperty
  a_reset_active: assert property (p_reset_active) else $error("mode not active after reset");

  property p_sleep_entry;
    @(posedge clk_sys) disable iff (!rstn)
      s_sleep_wake |=> state == PMC_ST_RESUME && from_sleep;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep wakeup not taken");

  property p_sleep_resume;
    @(posedge clk_sys) disable iff (!rstn)
      (state == PMC_ST_RESUME && from_sleep) |-> resume_age < PMC_CNT_W'(SLEEP_WAKE_CYC);
  endproperty
  a_sleep_resume: assert property (p_sleep_resume) else $error("sleep wakeup too slow");

  property p_hib_entry;
    @(posedge clk_sys) disable iff (!rstn)
      s_hib_wake |=> state == PMC_ST_RESUME && !from_sleep;
  endproperty
  a_hib_entry: assert property (p_hib_entry) else $error("pin wake not taken");

  property p_hib_resume;
    @(posedge clk_sys) disable iff (!rstn)
      (state == PMC_ST_RESUME && !from_sleep) |-> resume_age < PMC_CNT_W'(HIB_WAKE_CYC);
  endproperty
  a_hib_resume: assert property (p_hib_resume) else $error("hibernate resume failed");

  property p_hib_ignore;
    @(posedge clk_sys) disable iff (!rstn)
      (state == PMC_ST_HIB && !hib_wake) |=> state == PMC_ST_HIB;
  endproperty
  a_hib_ignore: assert property (p_hib_ignore) else $error("left hibernate without pin wake");

  property p_hib_regs;
    @(posedge clk_sys) disable iff (!rstn)
      state == PMC_ST_HIB |-> reg_ctl == 4'b0001 && !slow_clk_en && io_hold && sub_clk_en == '0;
  endproperty
  a_hib_regs: assert property (p_hib_regs) else $error("hibernate outputs wrong");

  property p_wake_cpu;
    @(posedge clk_sys) disable iff (!rstn)
      (state == PMC_ST_ACTIVE && any_wake) |=> !cpu_off && cpu_force;
  endproperty
  a_wake_cpu: assert property (p_wake_cpu) else $error("cpu not re-enabled on wake");

  property p_template;
    @(posedge clk_sys) disable iff (!rstn)
      (state == PMC_ST_ACTIVE && $past(rstn)) |->
        sub_clk_en == (($past(act_template) | NSUB'(cpu_force)) & ~NSUB'(cpu_off));
  endproperty
  a_template: assert property (p_template) else $error("active enables differ from template");

  property p_sleep_keep;
    @(posedge clk_sys) disable iff (!rstn)
      ($past(state) == PMC_ST_SLEEP && state == PMC_ST_SLEEP) |-> sub_clk_en == keep;
  endproperty
  a_sleep_keep: assert property (p_sleep_keep) else $error("sleep enables wrong");

  property p_no_spont;
    @(posedge clk_sys) disable iff (!rstn)
      (state == PMC_ST_ACTIVE && !mode_req_wr) |=> state == PMC_ST_ACTIVE;
  endproperty
  a_no_spont: assert property (p_no_spont) else $error("low mode entered without request");
endmodule

/* File: testbench/pmc_tb.sv */
// Self-checking testbench for the power mode controller
`timescale 1ns/1ns
module testbench;
  import pmc_pkg::*;
  localparam int SWC = 4;
  localparam int HWC = 8;
  localparam int LIMIT = 20000;
  logic clk_sys;
  logic rstn;
  logic [PMC_NSUB-1:0] act_template;
  logic [PMC_NSUB-1:0] alt_template;
  logic mode_req_wr;
  pmc_req_type mode_req;
  logic cpu_self_off;
  logic ext_regulation;
  pmc_wake_type wake_in;
  logic [PMC_NSUB-1:0] sub_clk_en;
  logic [PMC_NSUB-1:0] sub_bias_en;
  logic slow_clk_en;
  logic io_hold;
  pmc_reg_type reg_ctl;
  logic [1:0] mode_now;
  logic wake_done;
  int failures;
  int check_count;
  int cycles;
  int exp_mode;
  bit cpu_off;
  bit cpu_force;
  int cnt;
  logic [31:0] seed;

  pmc_top #(.SLEEP_WAKE_CYC(SWC), .HIB_WAKE_CYC(HWC)) pmc_top_i (
    .clk_sys(clk_sys), .rstn(rstn), .act_template(act_template),
    .alt_template(alt_template), .mode_req_wr(mode_req_wr), .mode_req(mode_req),
    .cpu_self_off(cpu_self_off), .ext_regulation(ext_regulation), .wake_in(wake_in),
    .sub_clk_en(sub_clk_en), .sub_bias_en(sub_bias_en), .slow_clk_en(slow_clk_en),
    .io_hold(io_hold), .reg_ctl(reg_ctl), .mode_now(mode_now), .wake_done(wake_done)
  );

  // ----------------------------------------
  // Clock, timeout, model, compares
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      conclude();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [PMC_NSUB-1:0] exp_en();
    logic [PMC_NSUB-1:0] e;
    case (exp_mode)
      0: e = act_template;
      1: e = alt_template;
      2: e = PMC_SLEEP_KEEP;
      default: e = '0;
    endcase
    if (exp_mode == 0 && cpu_force) e[PMC_SUB_CPU] = 1'b1;
    if (cpu_off) e[PMC_SUB_CPU] = 1'b0;
    return e;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_all();
    chk(32'(mode_now), 32'(exp_mode));
    chk(32'(sub_clk_en), 32'(exp_en()));
    chk(32'(sub_bias_en), 32'(exp_en()));
    chk_flag(io_hold, exp_mode == 3);
    chk_flag(slow_clk_en, exp_mode != 3);
    chk_flag(reg_ctl.hib_reg_on, exp_mode == 3);
    chk_flag(reg_ctl.sleep_reg_on, exp_mode == 2);
    if (exp_mode < 2) chk(32'(reg_ctl), 32'(4'b1100));
  endtask

  // Request is ignored by the model in sleep and hibernate
  task automatic req(input pmc_req_type m);
    @(posedge clk_sys);
    mode_req_wr <= 1'b1;
    mode_req <= m;
    @(posedge clk_sys);
    mode_req_wr <= 1'b0;
    if (exp_mode < 2) begin
      exp_mode = int'(m);
      cpu_force = 1'b0;
    end
    @(negedge clk_sys);
  endtask

  task automatic wake(input int k, input int bound);
    int w;
    @(posedge clk_sys);
    wake_in <= pmc_wake_type'(6'(1) << k);
    w = 0;
    @(negedge clk_sys);
    while (wake_done !== 1'b1 && w < bound) begin
      @(negedge clk_sys);
      w++;
    end
    chk_flag(wake_done, 1'b1);
    exp_mode = 0;
    cpu_off = 1'b0;
    cpu_force = 1'b1;
    check_all();
    @(posedge clk_sys);
    wake_in <= '0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic new_templates(input logic cpu_on);
    @(posedge clk_sys);
    act_template <= PMC_NSUB'(xs()) | PMC_NSUB'(cpu_on);
    alt_template <= PMC_NSUB'(xs());
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic conclude();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h889a_9ec9;
    rstn = 1'b0;
    act_template = 8'h5b;
    alt_template = 8'h34;
    mode_req_wr = 1'b0;
    mode_req = PMC_REQ_ACTIVE;
    cpu_self_off = 1'b0;
    ext_regulation = 1'b0;
    wake_in = '0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    exp_mode = 0;
    check_all();
    $display("test reset done");
    repeat (20) begin
      new_templates(1'b0);
      check_all();
    end
    req(PMC_REQ_ALT);
    check_all();
    repeat (10) begin
      new_templates(1'b0);
      check_all();
    end
    req(PMC_REQ_ACTIVE);
    check_all();
    req(PMC_REQ_ALT);
    @(posedge clk_sys);
    wake_in <= pmc_wake_type'(6'b00_0100);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    exp_mode = 0;
    cpu_force = 1'b1;
    check_all();
    @(posedge clk_sys);
    wake_in <= '0;
    repeat (2) @(posedge clk_sys);
    @(posedge clk_sys);
    ext_regulation <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(32'({reg_ctl.dig_reg_on, reg_ctl.ana_reg_on}), 32'(0));
    @(posedge clk_sys);
    ext_regulation <= 1'b0;
    $display("test templates done");
    for (int k = 0; k < PMC_NWAKE; k++) begin
      new_templates(k % 2 == 1);
      if (k == 0) begin
        @(posedge clk_sys);
        cpu_self_off <= 1'b1;
        @(posedge clk_sys);
        cpu_self_off <= 1'b0;
        cpu_off = 1'b1;
        cpu_force = 1'b0;
        @(negedge clk_sys);
        check_all();
      end
      req(PMC_REQ_SLEEP);
      check_all();
      if (k == 1) begin
        req(PMC_REQ_ACTIVE);
        check_all();
      end
      if (k == 0) begin
        cnt = 0;
        repeat (1100) begin
          @(negedge clk_sys);
          if (reg_ctl.dig_reg_on === 1'b1) cnt++;
        end
        chk(32'(cnt >= PMC_BUZZ_ON && cnt <= 2 * PMC_BUZZ_ON), 32'(1));
      end
      wake(k, SWC + 6);
    end
    $display("test sleep done");
    req(PMC_REQ_HIB);
    check_all();
    chk(32'(reg_ctl), 32'(4'b0001));
    for (int k = 0; k < PMC_NWAKE; k++) begin
      if (pmc_wake_type'(6'(1) << k) != pmc_wake_type'(6'b01_0000)) begin
        @(posedge clk_sys);
        wake_in <= pmc_wake_type'(6'(1) << k);
        repeat (20) @(posedge clk_sys);
        wake_in <= '0;
        @(negedge clk_sys);
        check_all();
      end
    end
    wake(4, HWC + 6);
    $display("test hibernate done");
    conclude();
  end
endmodule
